// *** core/dct_pkg.sv ***
// dct_pkg: shared constants and carrier types for the dual 8-bit compare timer
// assumes a single 125 MHz system clock; no register bus, control arrives as plain ports
package dct_pkg;

    localparam int unsigned CNT_W = 8;

    // clock select codes (three bits per channel)
    localparam logic [2:0] CKS_STOP     = 3'h0;
    localparam logic [2:0] CKS_PRE_A    = 3'h1;
    localparam logic [2:0] CKS_PRE_B    = 3'h2;
    localparam logic [2:0] CKS_PRE_C    = 3'h3;
    localparam logic [2:0] CKS_CASCADE  = 3'h4;
    localparam logic [2:0] CKS_EXT_RISE = 3'h5;
    localparam logic [2:0] CKS_EXT_FALL = 3'h6;
    localparam logic [2:0] CKS_EXT_BOTH = 3'h7;

    // clear select codes
    localparam logic [1:0] CLR_NONE  = 2'h0;
    localparam logic [1:0] CLR_MATCH_A = 2'h1;
    localparam logic [1:0] CLR_MATCH_B = 2'h2;
    localparam logic [1:0] CLR_EXT   = 2'h3;

    // output select codes
    localparam logic [1:0] OS_KEEP   = 2'h0;
    localparam logic [1:0] OS_LOW    = 2'h1;
    localparam logic [1:0] OS_HIGH   = 2'h2;
    localparam logic [1:0] OS_TOGGLE = 2'h3;

    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_MAX   = 8'hFF;
    localparam logic [CNT_W-1:0] MATCH_RESET = 8'hFF;

    // prescaler taps (internal clock = phi/2^(tap+1))
    localparam int unsigned PRE_W     = 13;
    localparam int unsigned TAP_A     = 2;
    localparam int unsigned TAP_B     = 5;
    localparam int unsigned TAP_C     = 12;

    // transfer vector indices
    localparam logic [1:0] VEC_A0 = 2'h0;
    localparam logic [1:0] VEC_B0 = 2'h1;
    localparam logic [1:0] VEC_A1 = 2'h2;
    localparam logic [1:0] VEC_B1 = 2'h3;

    typedef struct packed {
        logic [2:0] clock_select;
        logic [1:0] clear_select;
        logic       ext_clear_level_sel;
        logic [1:0] out_select_a;
        logic [1:0] out_select_b;
        logic       irq_en_a;
        logic       irq_en_b;
        logic       irq_en_ovf;
        logic       conv_trigger_enable;
    } dct_cfg_t;

    // one-cycle write strobes from the cpu side, data shared per channel
    typedef struct packed {
        logic             wr_count;
        logic             wr_match_a;
        logic             wr_match_b;
        logic [CNT_W-1:0] wdata;
        logic             clr_flag_a;
        logic             clr_flag_b;
        logic             clr_flag_ovf;
    } dct_wr_t;

    typedef struct packed {
        logic [CNT_W-1:0] timer_count;
        logic [CNT_W-1:0] match_value_a;
        logic [CNT_W-1:0] match_value_b;
        logic             match_flag_a;
        logic             match_flag_b;
        logic             overflow_flag;
    } dct_stat_t;

endpackage : dct_pkg

// *** core/dct_timer.sv ***
// dct_timer: two 8-bit compare timers with cascade, pin outputs, irq, transfer and a/d requests
// assumes all inputs synchronous to clk_sys_i apart from ext count/clear pins, which are resynchronised here
`timescale 1ns/1ps

module dct_timer #(
    parameter int unsigned CH_N = 2
) (
    input  wire logic                  clk_sys_i,
    input  wire logic                  arst_n_i,
    input  wire dct_pkg::dct_cfg_t     cfg_i        [CH_N],
    input  wire dct_pkg::dct_wr_t      wr_i         [CH_N],
    input  wire logic [CH_N-1:0]       ext_count_in_i,
    input  wire logic [CH_N-1:0]       ext_clear_in_i,
    output dct_pkg::dct_stat_t         stat_o       [CH_N],
    output logic [CH_N-1:0]            timer_out_pin_o,
    output logic [CH_N-1:0]            match_a_irq_o,
    output logic [CH_N-1:0]            match_b_irq_o,
    output logic [CH_N-1:0]            overflow_irq_o,
    output logic                       transfer_req_o,
    output logic [1:0]                 transfer_vector_index_o,
    output logic                       conv_start_o
);
    import dct_pkg::*;

    // shared prescaler; internal sources are divided levels watched for edges
    logic [PRE_W-1:0] prescale;
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            prescale <= '0;
        else
            prescale <= prescale + 1'b1;
    end

    wire mode16   = (cfg_i[0].clock_select == CKS_CASCADE);
    wire mode_cmc = (cfg_i[1].clock_select == CKS_CASCADE);
    wire both_cas = mode16 && mode_cmc;

    logic [CNT_W-1:0] count     [CH_N];
    logic [CNT_W-1:0] mval_a    [CH_N];
    logic [CNT_W-1:0] mval_b    [CH_N];
    logic [CH_N-1:0]  flag_a;
    logic [CH_N-1:0]  flag_b;
    logic [CH_N-1:0]  flag_ovf;
    logic [CH_N-1:0]  pin;
    logic [CH_N-1:0]  tick;
    logic [CH_N-1:0]  hit_a;
    logic [CH_N-1:0]  hit_b;
    logic [CH_N-1:0]  wrap;
    logic [CH_N-1:0]  clr;
    logic [CH_N-1:0]  ext_clr;

    // raw byte equality, before any mode or write suppression
    logic [CH_N-1:0] eq_a;
    logic [CH_N-1:0] eq_b;

    genvar g;
    generate
        for (g = 0; g < CH_N; g++)
        begin : g_ch
            // three-stage chains; stage two gives the clear level, stages two and three are compared for edges
            logic cnt_s1, cnt_s2, cnt_s3;
            logic clr_s1, clr_s2, clr_s3;
            logic src_prev;
            logic int_src;
            always_ff @(posedge clk_sys_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    cnt_s1   <= 1'b0;
                    cnt_s2   <= 1'b0;
                    cnt_s3   <= 1'b0;
                    clr_s1   <= 1'b0;
                    clr_s2   <= 1'b0;
                    clr_s3   <= 1'b0;
                    src_prev <= 1'b0;
                end
                else
                begin
                    cnt_s1   <= ext_count_in_i[g];
                    cnt_s2   <= cnt_s1;
                    cnt_s3   <= cnt_s2;
                    clr_s1   <= ext_clear_in_i[g];
                    clr_s2   <= clr_s1;
                    clr_s3   <= clr_s2;
                    src_prev <= int_src;
                end
            end

            // the selected internal level is compared with its previous value whatever the
            // select was, so a level step across a select change looks like an edge
            always_comb
            begin
                case (cfg_i[g].clock_select)
                    CKS_PRE_A: int_src = prescale[TAP_A];
                    CKS_PRE_B: int_src = prescale[TAP_B];
                    CKS_PRE_C: int_src = prescale[TAP_C];
                    default:   int_src = 1'b0;
                endcase
            end
            wire int_fall  = src_prev && !int_src;
            wire ext_rise  = cnt_s2 && !cnt_s3;
            wire ext_fall  = !cnt_s2 && cnt_s3;

            logic cas_tick;
            if (g == 0)
            begin : g_c0
                assign cas_tick = 1'b0;
            end
            else
            begin : g_c1
                // 16-bit mode: upper byte counts lower byte wraps, lower runs own clock
                assign cas_tick = 1'b0;
            end

            logic src_tick;
            always_comb
            begin
                case (cfg_i[g].clock_select)
                    CKS_PRE_A, CKS_PRE_B, CKS_PRE_C: src_tick = int_fall;
                    CKS_EXT_RISE: src_tick = ext_rise;
                    CKS_EXT_FALL: src_tick = ext_fall;
                    CKS_EXT_BOTH: src_tick = ext_rise || ext_fall;
                    default:      src_tick = cas_tick;
                endcase
            end
            assign ext_clr[g] = cfg_i[g].ext_clear_level_sel ? clr_s2 : (clr_s2 && !clr_s3);

            assign eq_a[g] = (count[g] == mval_a[g]);
            assign eq_b[g] = (count[g] == mval_b[g]);
            assign wrap[g] = tick[g] && (count[g] == CNT_MAX);

            // unit tick before cascade steering: ch1 in 16-bit mode uses its own source for the low byte
            logic own_tick;
            assign own_tick = src_tick;
        end
    endgenerate

    // cascade steering: ch0 is the upper byte in 16-bit mode and counts on lower-byte wrap
    wire base_tick0 = (cfg_i[0].clock_select == CKS_CASCADE) ? 1'b0 : g_ch[0].own_tick;
    wire low_tick   = g_ch[1].own_tick;
    assign tick[1] = !both_cas && (mode_cmc ? hit_a[0] : low_tick);
    assign tick[0] = !both_cas && (mode16 ? (tick[1] && count[1] == CNT_MAX) : base_tick0);

    // a match is taken in the last state the values agree, i.e. with the next count tick,
    // and a compare register write in the same cycle masks it
    wire eq16_a = eq_a[0] && eq_a[1];
    wire eq16_b = eq_b[0] && eq_b[1];
    assign hit_a[0] = tick[1'b0 ^ mode16] && (mode16 ? eq16_a : eq_a[0]) && !wr_i[0].wr_match_a;
    assign hit_b[0] = tick[1'b0 ^ mode16] && (mode16 ? eq16_b : eq_b[0]) && !wr_i[0].wr_match_b;
    assign hit_a[1] = tick[1] && eq_a[1] && !wr_i[1].wr_match_a;
    assign hit_b[1] = tick[1] && eq_b[1] && !wr_i[1].wr_match_b;

    // clear sources; in 16-bit mode only ch0 settings count and they clear both bytes
    function automatic logic clr_of(input logic [1:0] sel, input logic a, input logic b, input logic e);
        case (sel)
            CLR_MATCH_A: clr_of = a;
            CLR_MATCH_B: clr_of = b;
            CLR_EXT:     clr_of = e;
            default:     clr_of = 1'b0;
        endcase
    endfunction : clr_of

    wire clr16 = clr_of(cfg_i[0].clear_select, hit_a[0], hit_b[0], ext_clr[0])
                 || (mode16 && cfg_i[0].clear_select == CLR_EXT && (hit_a[0] || hit_b[0]));
    assign clr[0] = clr16;
    assign clr[1] = mode16 ? clr16 : clr_of(cfg_i[1].clear_select, hit_a[1], hit_b[1], ext_clr[1]);

    // next counter value: clear beats write, write beats increment
    logic [CNT_W-1:0] next_count [CH_N];
    generate
        for (g = 0; g < CH_N; g++)
        begin : g_cnt
            always_comb
            begin
                if (clr[g])
                    next_count[g] = CNT_RESET;
                else if (wr_i[g].wr_count)
                    next_count[g] = wr_i[g].wdata;
                else if (tick[g])
                    next_count[g] = count[g] + 1'b1;
                else
                    next_count[g] = count[g];
            end

            // output action with toggle > 1 > 0 > keep when both matches coincide
            logic [1:0] act;
            always_comb
            begin
                logic [1:0] sa;
                logic [1:0] sb;
                sa = hit_a[g] ? cfg_i[g].out_select_a : OS_KEEP;
                sb = hit_b[g] ? cfg_i[g].out_select_b : OS_KEEP;
                if (sa == OS_TOGGLE || sb == OS_TOGGLE)
                    act = OS_TOGGLE;
                else if (sa == OS_HIGH || sb == OS_HIGH)
                    act = OS_HIGH;
                else if (sa == OS_LOW || sb == OS_LOW)
                    act = OS_LOW;
                else
                    act = OS_KEEP;
            end

            logic next_pin;
            always_comb
            begin
                case (act)
                    OS_LOW:    next_pin = 1'b0;
                    OS_HIGH:   next_pin = 1'b1;
                    OS_TOGGLE: next_pin = !pin[g];
                    default:   next_pin = pin[g];
                endcase
            end

            // hardware set wins over a software clear in the same cycle
            wire next_fa = hit_a[g] || (flag_a[g]   && !wr_i[g].clr_flag_a);
            wire next_fb = hit_b[g] || (flag_b[g]   && !wr_i[g].clr_flag_b);
            wire next_fo = wrap[g]  || (flag_ovf[g] && !wr_i[g].clr_flag_ovf);

            always_ff @(posedge clk_sys_i or negedge arst_n_i)
            begin
                if (!arst_n_i)
                begin
                    count[g]    <= CNT_RESET;
                    mval_a[g]   <= MATCH_RESET;
                    mval_b[g]   <= MATCH_RESET;
                    flag_a[g]   <= 1'b0;
                    flag_b[g]   <= 1'b0;
                    flag_ovf[g] <= 1'b0;
                    pin[g]      <= 1'b0;
                end
                else
                begin
                    count[g]    <= next_count[g];
                    if (wr_i[g].wr_match_a)
                        mval_a[g] <= wr_i[g].wdata;
                    if (wr_i[g].wr_match_b)
                        mval_b[g] <= wr_i[g].wdata;
                    flag_a[g]   <= next_fa;
                    flag_b[g]   <= next_fb;
                    flag_ovf[g] <= next_fo;
                    pin[g]      <= next_pin;
                end
            end

            assign stat_o[g] = '{timer_count:   count[g],
                                 match_value_a: mval_a[g],
                                 match_value_b: mval_b[g],
                                 match_flag_a:  flag_a[g],
                                 match_flag_b:  flag_b[g],
                                 overflow_flag: flag_ovf[g]};
            assign timer_out_pin_o[g] = pin[g];
            assign match_a_irq_o[g]  = flag_a[g]   && cfg_i[g].irq_en_a;
            assign match_b_irq_o[g]  = flag_b[g]   && cfg_i[g].irq_en_b;
            assign overflow_irq_o[g] = flag_ovf[g] && cfg_i[g].irq_en_ovf;
        end
    endgenerate

    // transfer request follows irq priority: A0, B0, A1, B1; overflow never starts it
    always_comb
    begin
        transfer_req_o          = 1'b1;
        transfer_vector_index_o = VEC_A0;
        if (match_a_irq_o[0])
            transfer_vector_index_o = VEC_A0;
        else if (match_b_irq_o[0])
            transfer_vector_index_o = VEC_B0;
        else if (match_a_irq_o[1])
            transfer_vector_index_o = VEC_A1;
        else if (match_b_irq_o[1])
            transfer_vector_index_o = VEC_B1;
        else
            transfer_req_o = 1'b0;
    end

    // one-cycle start pulse registered from the setting event itself
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            conv_start_o <= 1'b0;
        else
            conv_start_o <= hit_a[0] && cfg_i[0].conv_trigger_enable;
    end

endmodule : dct_timer

// *** dv/dct_timer_sva.sv ***
// dct_timer_sva: port-level assertions for the dual compare timer
// assumes it is bound to dct_timer and sees only its ports
`timescale 1ns/1ps
module dct_timer_sva #(
    parameter int unsigned CH_N = 2
) (
    input wire logic               clk_sys_i,
    input wire logic               arst_n_i,
    input wire dct_pkg::dct_cfg_t  cfg_i [CH_N],
    input wire dct_pkg::dct_wr_t   wr_i [CH_N],
    input wire dct_pkg::dct_stat_t stat_o [CH_N],
    input wire logic [CH_N-1:0]    timer_out_pin_o,
    input wire logic [CH_N-1:0]    match_a_irq_o,
    input wire logic [CH_N-1:0]    match_b_irq_o,
    input wire logic [CH_N-1:0]    overflow_irq_o,
    input wire logic               transfer_req_o,
    input wire logic [1:0]         transfer_vector_index_o,
    input wire logic               conv_start_o
);
    import dct_pkg::*;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    // ch1 alone with no clear source: only ticks and writes can move its count
    wire logic       solo_1 = cfg_i[0].clock_select != CKS_CASCADE && cfg_i[1].clear_select == CLR_NONE;
    wire logic       both_c = cfg_i[0].clock_select == CKS_CASCADE && cfg_i[1].clock_select == CKS_CASCADE;
    wire logic       hit_a0 = cfg_i[0].clear_select == CLR_MATCH_A && cfg_i[0].clock_select != CKS_CASCADE
        && !wr_i[0].wr_count && !wr_i[0].wr_match_a && stat_o[0].timer_count == stat_o[0].match_value_a;
    wire logic [1:0] vec_e  = match_a_irq_o[0] ? VEC_A0 : match_b_irq_o[0] ? VEC_B0
        : match_a_irq_o[1] ? VEC_A1 : VEC_B1;

    pin_on_match_a: assert property (
        $changed(timer_out_pin_o[0]) |-> stat_o[0].match_flag_a || stat_o[0].match_flag_b) else $error("pin moved");
    irq_gate_a: assert property (
        match_a_irq_o == {stat_o[1].match_flag_a & cfg_i[1].irq_en_a, stat_o[0].match_flag_a & cfg_i[0].irq_en_a}
        && match_b_irq_o == {stat_o[1].match_flag_b & cfg_i[1].irq_en_b, stat_o[0].match_flag_b & cfg_i[0].irq_en_b})
        else $error("match irq gate");
    ovf_gate_a: assert property (
        overflow_irq_o == {stat_o[1].overflow_flag & cfg_i[1].irq_en_ovf, stat_o[0].overflow_flag & cfg_i[0].irq_en_ovf})
        else $error("overflow irq gate");
    xfer_prio_a: assert property (
        transfer_req_o == (|{match_a_irq_o, match_b_irq_o}) && (!transfer_req_o || transfer_vector_index_o == vec_e))
        else $error("transfer request or index");
    conv_start_a: assert property (
        $rose(stat_o[0].match_flag_a) && $past(cfg_i[0].conv_trigger_enable) |-> conv_start_o) else $error("no conv");
    conv_cause_a: assert property (
        conv_start_o |-> stat_o[0].match_flag_a && $past(cfg_i[0].conv_trigger_enable)) else $error("stray conv");
    ovf_wrap_a: assert property (
        $past(solo_1 && !wr_i[1].wr_count && stat_o[1].timer_count == CNT_MAX) && stat_o[1].timer_count == CNT_RESET
        |-> stat_o[1].overflow_flag) else $error("wrap without overflow");
    cnt_write_a: assert property (
        $past(solo_1 && wr_i[1].wr_count) |-> stat_o[1].timer_count == $past(wr_i[1].wdata)) else $error("write lost");
    cmp_write_a: assert property (
        $past(wr_i[1].wr_match_a) |-> stat_o[1].match_value_a == $past(wr_i[1].wdata)
        && !$rose(stat_o[1].match_flag_a)) else $error("compare write");
    match_clear_a: assert property (
        $past(hit_a0) && $changed(stat_o[0].timer_count) |-> stat_o[0].timer_count == CNT_RESET
        && stat_o[0].match_flag_a) else $error("no clear on match");
    both_stop_a: assert property (
        both_c && $past(both_c) && cfg_i[0].clear_select != CLR_EXT && !wr_i[0].wr_count && !wr_i[1].wr_count
        |=> $stable(stat_o[0].timer_count) && $stable(stat_o[1].timer_count)) else $error("count moved");

    cover property (conv_start_o);
    cover property ($rose(stat_o[1].overflow_flag));
    cover property (both_c [*8]);
endmodule : dct_timer_sva

// *** dv/dct_pin_model.sv ***
// dct_pin_model: drives the external count and clear pins of both channels
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
module dct_pin_model #(
    parameter int unsigned HOLD_CYC = 3
) (
    input  wire logic  clk_sys_i,
    output logic [1:0] ext_count_o,
    output logic [1:0] ext_clear_o
);
    initial
    begin
        ext_count_o = 2'h0;
        ext_clear_o = 2'h0;
    end
    // three clocks per level keeps clear of the dual-edge floor
    task automatic pulse_count(input int ch, input int n);
        repeat (n)
        begin
            @(negedge clk_sys_i);
            ext_count_o[ch] = 1'h1;
            repeat (HOLD_CYC) @(negedge clk_sys_i);
            ext_count_o[ch] = 1'h0;
            repeat (HOLD_CYC - 1) @(negedge clk_sys_i);
        end
    endtask : pulse_count
    task automatic set_clear(input int ch, input logic lvl);
        @(negedge clk_sys_i);
        ext_clear_o[ch] = lvl;
    endtask : set_clear
    task automatic pulse_clear(input int ch, input int width);
        set_clear(ch, 1'h1);
        repeat ((width < 2) ? 2 : width) @(negedge clk_sys_i);
        ext_clear_o[ch] = 1'h0;
    endtask : pulse_clear
endmodule : dct_pin_model

// *** dv/tb.sv ***
// tb: directed tests for the dual compare timer, checker bound below
// assumes dct_pin_model owns the external pins
`timescale 1ns/1ps
module tb;
    import dct_pkg::*;
    localparam int unsigned CH_N = 2;
    logic       clk;
    logic       arst_n;
    dct_cfg_t   cfg [CH_N];
    dct_wr_t    wr [CH_N];
    dct_stat_t  st [CH_N];
    logic [1:0] ecnt, eclr, pin, irq_a, irq_b, irq_o, vec;
    logic       treq, conv, xpin;
    int         errors, samples_checked, cyc;
    dct_timer #(.CH_N(CH_N)) uut (.clk_sys_i(clk), .arst_n_i(arst_n), .cfg_i(cfg), .wr_i(wr),
        .ext_count_in_i(ecnt), .ext_clear_in_i(eclr), .stat_o(st), .timer_out_pin_o(pin), .match_a_irq_o(irq_a),
        .match_b_irq_o(irq_b), .overflow_irq_o(irq_o), .transfer_req_o(treq), .transfer_vector_index_o(vec),
        .conv_start_o(conv));
    dct_pin_model u_pins (.clk_sys_i(clk), .ext_count_o(ecnt), .ext_clear_o(eclr));
    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] expv);
        samples_checked++;
        if (seen !== expv)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask : check
    task automatic conclude();
        if (errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude
    // kind bits: 0 count, 1 match a, 2 match b, 3 clear all flags
    task automatic wreg(input int ch, input logic [3:0] k, input logic [7:0] d);
        @(negedge clk);
        wr[ch] = '{wr_count: k[0], wr_match_a: k[1], wr_match_b: k[2], wdata: d,
                   clr_flag_a: k[3], clr_flag_b: k[3], clr_flag_ovf: k[3]};
        @(negedge clk);
        wr[ch] = '0;
    endtask : wreg
    // returns at the first falling edge after the count leaves n
    task automatic wait_leave(input int ch, input logic [7:0] n, output int k);
        k = 0;
        while (st[ch].timer_count !== n && k < 5000)
        begin
            @(negedge clk);
            k++;
        end
        while (st[ch].timer_count === n && k < 5000)
        begin
            @(negedge clk);
            k++;
        end
        if (k >= 5000)
            errors++;
    endtask : wait_leave
    function automatic logic pin_next(input logic p, input logic [1:0] a, input logic [1:0] b);
        if (a == OS_TOGGLE || b == OS_TOGGLE)
            return ~p;
        if (a == OS_HIGH || b == OS_HIGH)
            return 1'h1;
        if (a == OS_LOW || b == OS_LOW)
            return 1'h0;
        return p;
    endfunction : pin_next
    initial
    begin
        #300000;
        errors++;
        conclude();
    end
    initial
    begin
        arst_n = 1'h0;
        cfg = '{default: '0};
        wr = '{default: '0};
        errors = 0;
        samples_checked = 0;
        repeat (16) @(negedge clk);
        arst_n = 1'h1;
        check({pin, st[0].match_value_a, st[1].timer_count}, {2'h0, MATCH_RESET, CNT_RESET});
        // a and b share one compare value so every output pairing coincides
        wreg(0, 4'h6, 8'h03);
        cfg[0] = '{clock_select: CKS_PRE_A, clear_select: CLR_MATCH_A, irq_en_a: 1'h1,
                   conv_trigger_enable: 1'h1, default: '0};
        repeat (12) @(negedge clk);
        check(pin, 2'h0);
        xpin = 1'h0;
        for (int i = 0; i < 16; i++)
        begin
            cfg[0].out_select_a = i[1:0];
            cfg[0].out_select_b = i[3:2];
            wait_leave(0, 8'h03, cyc);
            xpin = pin_next(xpin, i[1:0], i[3:2]);
            check(pin[0], xpin);
            check({st[0].timer_count, irq_a, irq_b, conv, treq, vec}, {CNT_RESET, 2'h1, 2'h0, 2'h3, VEC_A0});
            wreg(0, 4'h8, 8'h00);
        end
        cfg[0].conv_trigger_enable = 1'h0;
        wait_leave(0, 8'h03, cyc);
        wait_leave(0, 8'h03, cyc);
        check(cyc[15:0], 16'(4 * (2 ** (TAP_A + 1))));
        check(conv, 1'h0);
        cfg[0] = '{irq_en_b: 1'h1, default: '0};
        @(negedge clk);
        check({treq, vec}, {1'h1, VEC_B0});
        wreg(0, 4'h8, 8'h00);
        cfg[1] = '{clock_select: CKS_PRE_A, irq_en_ovf: 1'h1, default: '0};
        wreg(1, 4'h1, 8'hFE);
        wait_leave(1, 8'hFF, cyc);
        check({st[1].timer_count, st[1].overflow_flag, irq_o, treq}, {CNT_RESET, 1'h1, 2'h2, 1'h0});
        for (int i = 0; i < 8; i++)
        begin
            @(negedge clk);
            wreg(1, 4'h1, 8'h40);
            check(st[1].timer_count, 16'h0040);
        end
        cfg[1] = '0;
        for (int m = 0; m < 3; m++)
        begin
            cfg[0].clock_select = (m == 0) ? CKS_EXT_RISE : (m == 1) ? CKS_EXT_FALL : CKS_EXT_BOTH;
            wreg(0, 4'h1, 8'h00);
            u_pins.pulse_count(0, 5);
            repeat (6) @(negedge clk);
            check(st[0].timer_count, (m == 2) ? 16'h000A : 16'h0005);
        end
        cfg[0].clear_select = CLR_EXT;
        wreg(0, 4'h1, 8'h09);
        check(st[0].timer_count, 16'h0009);
        u_pins.pulse_clear(0, 2);
        repeat (4) @(negedge clk);
        check(st[0].timer_count, 16'h0000);
        cfg[0].ext_clear_level_sel = 1'h1;
        u_pins.set_clear(0, 1'h1);
        repeat (4) @(negedge clk);
        wreg(0, 4'h1, 8'h55);
        check(st[0].timer_count, 16'h0000);
        u_pins.set_clear(0, 1'h0);
        cfg[0] = '0;
        wreg(0, 4'h9, 8'h12);
        wreg(0, 4'h2, 8'h13);
        wreg(1, 4'h9, 8'hFE);
        wreg(1, 4'h2, 8'hFF);
        cfg[0].clock_select = CKS_CASCADE;
        cfg[1].clock_select = CKS_PRE_A;
        wait_leave(1, 8'hFF, cyc);
        check({st[0].timer_count, st[1].timer_count}, 16'h1300);
        check({st[0].match_flag_a, st[1].match_flag_a}, 2'h1);
        cfg = '{default: '0};
        wreg(0, 4'h9, 8'h00);
        wreg(0, 4'h2, 8'h01);
        wreg(1, 4'h1, 8'h00);
        cfg[1].clock_select = CKS_CASCADE;
        cfg[0] = '{clock_select: CKS_PRE_A, clear_select: CLR_MATCH_A, default: '0};
        wait_leave(0, 8'h01, cyc);
        wait_leave(0, 8'h01, cyc);
        repeat (2) @(negedge clk);
        check(st[1].timer_count, 16'h0002);
        cfg[0].clock_select = CKS_CASCADE;
        wreg(0, 4'h1, 8'h05);
        wreg(1, 4'h1, 8'h07);
        repeat (64) @(negedge clk);
        check({st[0].timer_count, st[1].timer_count}, 16'h0507);
        conclude();
    end
endmodule : tb

bind dct_timer dct_timer_sva #(.CH_N(CH_N)) u_sva (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .cfg_i(cfg_i),
    .wr_i(wr_i), .stat_o(stat_o), .timer_out_pin_o(timer_out_pin_o), .match_a_irq_o(match_a_irq_o),
    .match_b_irq_o(match_b_irq_o), .overflow_irq_o(overflow_irq_o), .transfer_req_o(transfer_req_o),
    .transfer_vector_index_o(transfer_vector_index_o), .conv_start_o(conv_start_o));
